//--- rtl/rar_cfg.svh
// Register map and field constants for the remote alias remap block
`ifndef RAR_CFG_SVH
`define RAR_CFG_SVH
// ---------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ---------------------------------------------------------------------
`define RAR_IDX_PHYS_BASE 8'h08
`define RAR_IDX_PHYS_5 8'h0D
`define RAR_IDX_PHYS_6 8'h0E
`define RAR_IDX_PHYS_7 8'h0F
`define RAR_IDX_ALIAS_BASE 8'h10
`define RAR_IDX_ALIAS_0 8'h10
`define RAR_IDX_ALIAS_1 8'h11
`define RAR_IDX_STATUS 8'h18
// ---------------------------------------------------------------------
// Field layout and reset values
// ---------------------------------------------------------------------
`define RAR_ADDR_MSB 7
`define RAR_ADDR_LSB 1
`define RAR_RW_BIT 0
`define RAR_ADDR_RESET 7'h00
`define RAR_ALIAS_OFF 7'h00
`define RAR_IDX_LSB 2
`define RAR_IDX_MSB 9
`endif

//--- rtl/rar_pkg.sv
// Types shared by the remote alias remap block
package rar_pkg;
  typedef logic [6:0] rar_addr_t;
  typedef logic [2:0] rar_slot_t;
  typedef logic [31:0] rar_word_t;
endpackage : rar_pkg

//--- rtl/rar_match_if.sv
// Carrier between the register file and the alias decoder
`timescale 1ns/1ps
interface rar_match_if #(
  parameter int N_SLOTS = 8
);
  import rar_pkg::*;
  rar_addr_t alias_tab [N_SLOTS];
  rar_addr_t phys_tab [N_SLOTS];
  rar_addr_t query;
  logic hit;
  rar_slot_t slot;
  rar_addr_t phys;
  modport table_side (output alias_tab, output phys_tab, output query,
    input hit, input slot, input phys);
  modport decoder (input alias_tab, input phys_tab, input query,
    output hit, output slot, output phys);
endinterface : rar_match_if

//--- rtl/rar_alias_match.sv
// Alias decoder: finds the slot whose alias equals the query address
`timescale 1ns/1ps
`include "rar_cfg.svh"
module rar_alias_match #(
  parameter int N_SLOTS = 8
) (
  rar_match_if.decoder m
);
  import rar_pkg::*;
  logic [N_SLOTS-1:0] slot_hit;

  // -------------------------------------------------------------------
  // Per-slot compare; a zero alias never matches
  // -------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_SLOTS; g++) begin : g_cmp
      assign slot_hit[g] = (m.alias_tab[g] != `RAR_ALIAS_OFF) &&
                           (m.alias_tab[g] == m.query);
    end
  endgenerate

  // Lowest slot wins when software programs the same alias twice
  function automatic rar_slot_t first_hit(input logic [N_SLOTS-1:0] v);
    rar_slot_t r;
    r = '0;
    for (int i = N_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = rar_slot_t'(i);
      end
    end
    return r;
  endfunction : first_hit

  assign m.hit = |slot_hit;
  assign m.slot = first_hit(slot_hit);
  assign m.phys = m.phys_tab[m.slot];
endmodule : rar_alias_match

//--- rtl/rar_remap.sv
// Top of the remote alias remap block: APB registers and address swap
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "rar_cfg.svh"
module rar_remap #(
  parameter int N_SLOTS = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire rar_pkg::rar_word_t pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output rar_pkg::rar_word_t prdata,
  output logic pslverr,
  input wire logic i2c_addr_valid,
  input wire logic [7:0] i2c_addr_byte,
  output logic fwd_valid,
  output logic [7:0] fwd_byte,
  output rar_pkg::rar_slot_t fwd_slot,
  output logic miss
);
  import rar_pkg::*;

  // -------------------------------------------------------------------
  // Parameter check
  // -------------------------------------------------------------------
  // The slot index is three bits and the map holds eight of each kind
  if (N_SLOTS != 8) begin : g_bad_slots
    $error("rar_remap supports exactly eight slots");
  end

  rar_addr_t phys_q [N_SLOTS];
  rar_addr_t alias_q [N_SLOTS];
  logic pready_q;
  rar_word_t prdata_q;
  logic pslverr_q;
  logic fwd_valid_q;
  logic [7:0] fwd_byte_q;
  rar_slot_t fwd_slot_q;
  logic miss_q;
  logic [7:0] hit_cnt_q;
  logic [7:0] miss_cnt_q;

  rar_match_if #(.N_SLOTS(N_SLOTS)) mif ();

  // -------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    return a[`RAR_IDX_MSB:`RAR_IDX_LSB];
  endfunction : reg_index

  function automatic logic idx_mapped(input logic [7:0] i);
    return (i >= `RAR_IDX_PHYS_BASE && i <= `RAR_IDX_PHYS_7) ||
           (i >= `RAR_IDX_ALIAS_BASE &&
            i < `RAR_IDX_ALIAS_BASE + 8'(N_SLOTS)) ||
           (i == `RAR_IDX_STATUS);
  endfunction : idx_mapped

  logic [7:0] idx;
  logic access;
  logic wr_done;
  logic [1:0] low_bits;
  assign idx = reg_index(paddr);
  assign low_bits = paddr[1:0];
  // Answer one cycle into the access phase so pready is a flop
  assign access = psel && penable && !pready_q;
  assign wr_done = psel && penable && pready_q && pwrite && pstrb[0] &&
                   !pslverr_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access;
      pslverr_q <= access && (!idx_mapped(idx) || low_bits != 2'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_q <= '0;
    end else if (access && !pwrite) begin
      prdata_q <= '0;
      if (idx >= `RAR_IDX_PHYS_BASE && idx <= `RAR_IDX_PHYS_7) begin
        prdata_q[`RAR_ADDR_MSB:`RAR_ADDR_LSB] <=
          phys_q[3'(idx - `RAR_IDX_PHYS_BASE)];
      end else if (idx >= `RAR_IDX_ALIAS_BASE &&
                   idx < `RAR_IDX_ALIAS_BASE + 8'(N_SLOTS)) begin
        prdata_q[`RAR_ADDR_MSB:`RAR_ADDR_LSB] <=
          alias_q[3'(idx - `RAR_IDX_ALIAS_BASE)];
      end else if (idx == `RAR_IDX_STATUS) begin
        prdata_q[15:0] <= {miss_cnt_q, hit_cnt_q};
      end
    end
  end

  // -------------------------------------------------------------------
  // Address tables; bit 0 of each register is reserved and reads zero
  // -------------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < N_SLOTS; s++) begin : g_slot
      always_ff @(posedge clk) begin
        if (reset) begin
          phys_q[s] <= `RAR_ADDR_RESET;
        end else if (wr_done && idx == `RAR_IDX_PHYS_BASE + 8'(s)) begin
          phys_q[s] <= pwdata[`RAR_ADDR_MSB:`RAR_ADDR_LSB];
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          alias_q[s] <= `RAR_ADDR_RESET;
        end else if (wr_done && idx == `RAR_IDX_ALIAS_BASE + 8'(s)) begin
          alias_q[s] <= pwdata[`RAR_ADDR_MSB:`RAR_ADDR_LSB];
        end
      end
      assign mif.alias_tab[s] = alias_q[s];
      assign mif.phys_tab[s] = phys_q[s];
    end
  endgenerate

  // -------------------------------------------------------------------
  // Address substitution
  // -------------------------------------------------------------------
  assign mif.query = i2c_addr_byte[`RAR_ADDR_MSB:`RAR_ADDR_LSB];

  rar_alias_match #(.N_SLOTS(N_SLOTS)) u_match (
    .m(mif.decoder)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      fwd_valid_q <= 1'b0;
      fwd_byte_q <= '0;
      fwd_slot_q <= '0;
      miss_q <= 1'b0;
    end else begin
      fwd_valid_q <= i2c_addr_valid && mif.hit;
      miss_q <= i2c_addr_valid && !mif.hit;
      if (i2c_addr_valid && mif.hit) begin
        fwd_byte_q <= {mif.phys, i2c_addr_byte[`RAR_RW_BIT]};
        fwd_slot_q <= mif.slot;
      end
    end
  end

  // Counters saturate so software never sees a wrap as a small count
  always_ff @(posedge clk) begin
    if (reset) begin
      hit_cnt_q <= '0;
      miss_cnt_q <= '0;
    end else begin
      if (fwd_valid_q && hit_cnt_q != 8'hFF) begin
        hit_cnt_q <= hit_cnt_q + 8'h01;
      end
      if (miss_q && miss_cnt_q != 8'hFF) begin
        miss_cnt_q <= miss_cnt_q + 8'h01;
      end
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign fwd_valid = fwd_valid_q;
  assign fwd_byte = fwd_byte_q;
  assign fwd_slot = fwd_slot_q;
  assign miss = miss_q;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic wr_phys_q;
  logic wr_alias_q;
  logic wr_any_q;
  rar_slot_t wr_slot_q;
  rar_addr_t wr_val_q;
  rar_addr_t m_phys;
  logic m_hit;
  assign m_phys = mif.phys;
  assign m_hit = mif.hit;
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_phys_q <= 1'b0;
      wr_alias_q <= 1'b0;
      wr_any_q <= 1'b0;
      wr_slot_q <= '0;
      wr_val_q <= '0;
    end else begin
      wr_phys_q <= wr_done && idx >= `RAR_IDX_PHYS_BASE &&
                   idx <= `RAR_IDX_PHYS_7;
      wr_alias_q <= wr_done && idx >= `RAR_IDX_ALIAS_BASE &&
                    idx < `RAR_IDX_ALIAS_BASE + 8'(N_SLOTS);
      wr_any_q <= wr_done;
      wr_slot_q <= idx[2:0];
      wr_val_q <= pwdata[`RAR_ADDR_MSB:`RAR_ADDR_LSB];
    end
  end

  property p_phys_store;
    wr_phys_q |-> phys_q[wr_slot_q] == wr_val_q;
  endproperty
  a_phys_store: assert property (p_phys_store)
    else $error("physical address write not stored");

  property p_remap;
    i2c_addr_valid && m_hit |=>
      fwd_valid_q && fwd_byte_q[7:1] == $past(m_phys);
  endproperty
  a_remap: assert property (p_remap)
    else $error("matched address not replaced");

  property p_alias_store;
    wr_alias_q |-> alias_q[wr_slot_q] == wr_val_q;
  endproperty
  a_alias_store: assert property (p_alias_store)
    else $error("alias write not stored");

  property p_pairing;
    fwd_valid_q && !wr_any_q |->
      phys_q[fwd_slot_q] == fwd_byte_q[7:1] &&
      alias_q[fwd_slot_q] == $past(i2c_addr_byte[7:1]);
  endproperty
  a_pairing: assert property (p_pairing)
    else $error("alias slot not paired with same physical slot");

  property p_zero_off;
    i2c_addr_valid && i2c_addr_byte[7:1] == 7'h00 |=> !fwd_valid_q ##0 miss_q;
  endproperty
  a_zero_off: assert property (p_zero_off)
    else $error("zero alias matched a transaction");

  // A write landing with the pulse may legally clear the alias just used
  property p_slot_range;
    fwd_valid_q && !wr_any_q |-> alias_q[fwd_slot_q] != `RAR_ALIAS_OFF;
  endproperty
  a_slot_range: assert property (p_slot_range)
    else $error("forward through a disabled slot");

  property p_rw_pass;
    i2c_addr_valid |=> (fwd_valid_q || miss_q) &&
      (!fwd_valid_q || fwd_byte_q[0] == $past(i2c_addr_byte[0]));
  endproperty
  a_rw_pass: assert property (p_rw_pass)
    else $error("direction bit altered");

  property p_apb_answer;
    psel && penable && !pready_q |=> pready_q ##1 !pready_q;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not one cycle after access");
endmodule : rar_remap

//--- test/rar_i2c_partner.sv
// Local bus master model: offers first bytes and collects the answers
`timescale 1ns/1ps
module rar_i2c_partner (
  input wire logic clk,
  output logic i2c_addr_valid,
  output logic [7:0] i2c_addr_byte,
  input wire logic fwd_valid,
  input wire logic [7:0] fwd_byte,
  input wire logic miss
);
  initial begin
    i2c_addr_valid = 1'b0;
    i2c_addr_byte = 8'h00;
  end
  // The answer is sampled one edge after the edge that takes the pulse
  task automatic send(input logic [7:0] b, output logic hit,
      output logic mis, output logic [7:0] fb);
    @(posedge clk);
    i2c_addr_valid <= 1'b1;
    i2c_addr_byte <= b;
    @(posedge clk);
    i2c_addr_valid <= 1'b0;
    // Released byte lane must not keep showing the old address
    i2c_addr_byte <= ~b;
    @(posedge clk);
    hit = fwd_valid;
    mis = miss;
    fb = fwd_byte;
  endtask : send
endmodule : rar_i2c_partner

//--- test/tb_top.sv
// Self-checking bench for the remote alias remap block
`timescale 1ns/1ps
`include "rar_cfg.svh"
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin \
  n_mismatch++; $display("unexpected at %0t: %s", $time, m); end end
module tb_top;
  import rar_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  rar_word_t pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, i2c_addr_valid, fwd_valid, miss;
  rar_word_t prdata;
  logic [7:0] i2c_addr_byte, fwd_byte;
  rar_slot_t fwd_slot;
  int n_mismatch = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  rar_remap #(.N_SLOTS(8)) dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .i2c_addr_valid(i2c_addr_valid), .i2c_addr_byte(i2c_addr_byte),
    .fwd_valid(fwd_valid), .fwd_byte(fwd_byte), .fwd_slot(fwd_slot),
    .miss(miss));
  rar_i2c_partner master (.clk(clk), .i2c_addr_valid(i2c_addr_valid),
    .i2c_addr_byte(i2c_addr_byte), .fwd_valid(fwd_valid),
    .fwd_byte(fwd_byte), .miss(miss));
  // ---------------------------------------------------------------
  // Bus and transfer helpers
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] idx,
      input rar_word_t wd, output rar_word_t rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) `CHK(1'b0, 1'b1, "bus hang")
  endtask : apb
  task automatic wr(input logic [7:0] idx, input rar_word_t d);
    rar_word_t rd;
    logic er;
    apb(1'b1, idx, d, rd, er);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input rar_word_t e);
    rar_word_t rd;
    logic er;
    apb(1'b0, idx, 32'h00000000, rd, er);
    `CHK(rd, e, "register read")
  endtask : rdchk
  // Hit expected: forward pulse seen at the one sample edge with byte efb, no miss
  task automatic xfer(input logic [7:0] b, input logic eh,
      input logic [7:0] efb);
    logic h, m;
    logic [7:0] fb;
    master.send(b, h, m, fb);
    `CHK({h, m}, {eh, ~eh}, "hit or miss pulse")
    if (eh) `CHK(fb, efb, "forwarded byte")
  endtask : xfer
  task automatic t_reset;
    logic [7:0] ix [5] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11};
    foreach (ix[i]) rdchk(ix[i], 32'h00000000);
    $display("reset values done");
  endtask : t_reset
  task automatic t_fields;
    rar_word_t rd;
    logic er;
    wr(`RAR_IDX_PHYS_5, 32'hFFFFFFFF);
    rdchk(`RAR_IDX_PHYS_5, 32'h000000FE);
    wr(`RAR_IDX_ALIAS_0, 32'hFFFFFF01);
    rdchk(`RAR_IDX_ALIAS_0, 32'h00000000);
    pstrb <= 4'hE;
    wr(`RAR_IDX_PHYS_5, 32'h00000000);
    pstrb <= 4'hF;
    rdchk(`RAR_IDX_PHYS_5, 32'h000000FE);
    apb(1'b0, 8'h3F, 32'h00000000, rd, er);
    `CHK({er, rd}, {1'b1, 32'h00000000}, "unmapped read")
    $display("field layout done");
  endtask : t_fields
  task automatic t_remap;
    xfer(8'h00, 1'b0, 8'h00);
    xfer(8'hA0, 1'b0, 8'h00);
    wr(`RAR_IDX_ALIAS_1, 32'h00000054);
    wr(8'h09, 32'h000000A0);
    xfer(8'h55, 1'b1, 8'hA1);
    `CHK(fwd_slot, 3'd1, "slot")
    xfer(8'h54, 1'b1, 8'hA0);
    xfer(8'h56, 1'b0, 8'h00);
    wr(`RAR_IDX_ALIAS_1, 32'h00000000);
    xfer(8'h55, 1'b0, 8'h00);
    rdchk(`RAR_IDX_STATUS, 32'h00000402);
    $display("remap done");
  endtask : t_remap
  task automatic t_upper;
    for (int k = 5; k < 8; k++) begin
      wr(8'h10 + 8'(k), {24'h0, 7'(8'h10 + k), 1'b0});
      wr(8'h08 + 8'(k), {24'h0, 7'(8'h60 + k), 1'b0});
    end
    for (int k = 5; k < 8; k++) begin
      xfer({7'(8'h10 + k), 1'b1}, 1'b1, {7'(8'h60 + k), 1'b1});
      `CHK(fwd_slot, 3'(k), "slot")
    end
    $display("upper slots done");
  endtask : t_upper
  // Reset in mid-run must wipe tables that were programmed before it
  task automatic t_rerun;
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    `CHK({fwd_valid, miss, fwd_byte, fwd_slot}, 13'h0000, "reset out")
    rdchk(`RAR_IDX_PHYS_7, 32'h00000000);
    rdchk(8'h15, 32'h00000000);
    xfer(8'h2B, 1'b0, 8'h00);
    $display("mid-run reset done");
  endtask : t_rerun
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_remap();
    t_upper();
    t_rerun();
    summarize();
  end
endmodule : tb_top
